// file: asp_audio_port.sv
// Purpose: Input and output serial audio ports of one converter section.
// Assumes: 250 MHz clk oversamples all serial clocks and pins.
// Notes: Resampling core sits outside on the core_* ports.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "asp_cfg.svh"
// How it works
// - Master input bit clock fixed 64 fs
// - Input word clock at fs, 50% duty
// - Three-bit input format code selects framing
// - Input format resets to 24-bit left-justified
// - Output words dithered down from 28 bits
// - Master output bit clock 64 fs or ref
// - Output word clock 50% or 32-bit pulse
// - Two-bit output format code selects framing
// - Two-bit word length code selects width
// - Output resets left-justified, 24 bits
// - Passthrough pin or bit routes input out
// - Passthrough disables dither and de-emphasis
// - Depth code picks 64, 32, 16, 8
// - Depth selection resets to 64 samples
// - Downsample bit picks filter or direct
// - De-emphasis code picks input sample rate
// - De-emphasis resets to disabled
// - Mode code picks master port and ratio
// - Input words two's complement, MSB first
module asp_audio_port
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sw_mode_pin,
   input wire logic [2:0] port_mode_pin,
   input wire logic [2:0] in_format_sel,
   input wire logic [1:0] out_format_sel,
   input wire logic [1:0] out_word_length_sel,
   input wire logic passthru_pin,
   input wire logic [1:0] buffer_depth_sel,
   input wire logic direct_downsample_sel,
   input wire logic [1:0] deemphasis_sel,
   input wire logic section_ref_clock,
   input wire logic in_bit_clock_i,
   output logic in_bit_clock_o,
   output logic in_bit_clock_oe_n,
   input wire logic in_word_clock_i,
   output logic in_word_clock_o,
   output logic in_word_clock_oe_n,
   input wire logic in_serial_data,
   input wire logic out_bit_clock_i,
   output logic out_bit_clock_o,
   output logic out_bit_clock_oe_n,
   input wire logic out_word_clock_i,
   output logic out_word_clock_o,
   output logic out_word_clock_oe_n,
   output logic out_serial_data,
   output logic [27:0] core_in_left,
   output logic [27:0] core_in_right,
   output logic core_in_valid,
   input wire logic [27:0] core_out_left,
   input wire logic [27:0] core_out_right,
   output logic core_out_take,
   output logic [6:0] cfg_buffer_depth,
   output logic cfg_direct_downsample,
   output logic [1:0] cfg_deemphasis,
   output logic bypass_active
);
   // Right-justified input width from format code
   function automatic logic [6:0] rj_bits(input logic [2:0] f);
      unique case (f[1:0])
         2'h0: rj_bits = 7'h10;
         2'h1: rj_bits = 7'h12;
         2'h2: rj_bits = 7'h14;
         2'h3: rj_bits = 7'h18;
      endcase
   endfunction : rj_bits

   // Output width from word length code
   function automatic logic [6:0] ow_bits(input logic [1:0] c);
      unique case (c)
         2'h0: ow_bits = 7'h18;
         2'h1: ow_bits = 7'h14;
         2'h2: ow_bits = 7'h12;
         2'h3: ow_bits = 7'h10;
      endcase
   endfunction : ow_bits

   // Master role decode from port mode code
   function automatic asp_pkg::asp_role_type role(input logic [2:0] m);
      if (m[1:0] == 2'h0)
         role = asp_pkg::ASP_ALL_SLAVE;
      else if (m[2])
         role = asp_pkg::ASP_IN_MASTER;
      else
         role = asp_pkg::ASP_OUT_MASTER;
   endfunction : role

   // Recover a 24-bit MSB-aligned word from the shifted half frame
   function automatic logic [23:0] in_word(input logic [2:0] f,
      input logic [31:0] s, input logic [6:0] n);
      logic [6:0] need;
      logic [31:0] t;
      need = (f[0] && !f[1]) ? `ASP_I2S_BITS : `ASP_LJ_BITS;
      if (f[2])
         t = s << (`ASP_LJ_BITS - rj_bits(f));
      else if (n >= need)
         t = s >> (n - need);
      else
         t = s << (need - n);
      in_word = t[23:0];
   endfunction : in_word

   // Reduce to w bits with optional triangular dither, saturating
   function automatic logic [23:0] dither(input logic [27:0] x,
      input logic [6:0] w, input logic [15:0] rnd, input logic byp);
      logic signed [29:0] acc;
      logic signed [9:0] tpdf;
      acc = $signed({x[27], x[27], x});
      tpdf = $signed({2'h0, rnd[7:0]}) + $signed({2'h0, rnd[15:8]})
         - 10'sd255;
      if (!byp)
         acc = acc + ((30'(tpdf) <<< (7'h1c - w)) >>> 8);
      if (acc > 30'sh07ffffff)
         acc = 30'sh07ffffff;
      else if (acc < -30'sh08000000)
         acc = -30'sh08000000;
      dither = acc[27:4] & ~(24'hffffff >> w[4:0]);
   endfunction : dither

   // Two-flop synchroniser for every pin from outside the clk domain
   logic [`ASP_SYNC_W-1:0] meta_r;
   logic [`ASP_SYNC_W-1:0] sync_r;
   always_ff @(posedge clk)
   begin
      meta_r <= {in_bit_clock_i, in_word_clock_i, in_serial_data,
         out_bit_clock_i, out_word_clock_i, section_ref_clock,
         sw_mode_pin, port_mode_pin, in_format_sel, out_format_sel,
         out_word_length_sel, passthru_pin, buffer_depth_sel,
         direct_downsample_sel, deemphasis_sel};
      sync_r <= meta_r;
   end
   logic s_ib, s_il, s_sd, s_ob, s_ol, s_ref, s_sw, s_byp, s_dds;
   logic [2:0] s_mode, s_infmt;
   logic [1:0] s_outfmt, s_wlen, s_dep, s_demph;
   assign {s_ib, s_il, s_sd, s_ob, s_ol, s_ref, s_sw, s_mode, s_infmt,
      s_outfmt, s_wlen, s_byp, s_dep, s_dds, s_demph} = sync_r;

   // Software control registers
   logic [7:0] ctl1_r, ctl2_r, ctl3_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctl1_r <= `ASP_CTL1_RST;
         ctl2_r <= `ASP_CTL2_RST;
         ctl3_r <= `ASP_CTL3_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `ASP_REG_CTL1)
            ctl1_r <= reg_wdata & 8'h0f;
         if (reg_addr == `ASP_REG_CTL2)
            ctl2_r <= reg_wdata & 8'h1f;
         if (reg_addr == `ASP_REG_CTL3)
            ctl3_r <= reg_wdata & 8'hf7;
      end
   end

   // Effective settings: registers in software mode, pins otherwise; the passthrough pin acts in both modes
   logic [2:0] mode, in_fmt;
   logic [1:0] out_fmt, wlen;
   logic [6:0] ow;
   logic in_master, out_master, tdm;
   asp_pkg::asp_role_type role_now;
   assign mode = s_sw ? ctl1_r[`ASP_F_MODE] : s_mode;
   assign in_fmt = s_sw ? ctl3_r[`ASP_F_INFMT] : s_infmt;
   assign out_fmt = s_sw ? ctl3_r[`ASP_F_OUTFMT] : s_outfmt;
   assign wlen = s_sw ? ctl3_r[`ASP_F_WLEN] : s_wlen;
   assign ow = ow_bits(wlen);
   assign role_now = role(mode);
   assign in_master = role_now == asp_pkg::ASP_IN_MASTER;
   assign out_master = role_now == asp_pkg::ASP_OUT_MASTER;
   assign tdm = out_fmt == `ASP_OUTFMT_TDM;
   assign bypass_active = s_byp | (s_sw & ctl1_r[`ASP_F_BYP]);
   assign cfg_buffer_depth = `ASP_DEPTH_MAX >>
      (s_sw ? ctl2_r[`ASP_F_DEPTH] : s_dep);
   assign cfg_direct_downsample = s_sw ? ctl2_r[`ASP_F_DDS] : s_dds;
   assign cfg_deemphasis = bypass_active ? 2'h0
      : (s_sw ? ctl2_r[`ASP_F_DEMPH] : s_demph);

   // Register read port, data one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         unique case (reg_addr)
            `ASP_REG_CTL1: reg_rdata <= ctl1_r;
            `ASP_REG_CTL2: reg_rdata <= ctl2_r;
            `ASP_REG_CTL3: reg_rdata <= ctl3_r;
            `ASP_REG_STAT: reg_rdata <= {4'h0, s_sw, bypass_active,
               out_master, in_master};
            default: reg_rdata <= 8'h00;
         endcase
      else
         reg_rdata <= 8'h00;
   end

   // Master clock generator from the reference clock
   logic ref_q, ref_rise, ref_fall, gbclk_r, tpulse_r;
   logic [2:0] div_r, half;
   logic [5:0] gbit_r;
   logic [9:0] tcnt_r, tlen;
   assign ref_rise = s_ref & ~ref_q;
   assign ref_fall = ~s_ref & ref_q;
   assign half = (mode[1:0] == 2'h1) ? 3'h1
      : (mode[1:0] == 2'h2) ? 3'h4 : 3'h2;
   assign tlen = {half, 7'h00};
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ref_q <= 1'b0;
         div_r <= 3'h0;
         gbclk_r <= 1'b0;
         gbit_r <= 6'h00;
      end
      else
      begin
         ref_q <= s_ref;
         // Half bit period of ratio/128 reference cycles gives 64 fs
         if (ref_rise && div_r >= half - 3'h1)
         begin
            div_r <= 3'h0;
            gbclk_r <= ~gbclk_r;
            if (gbclk_r)
               gbit_r <= gbit_r + 6'h01;
         end
         else if (ref_rise)
            div_r <= div_r + 3'h1;
      end
   end

   // TDM frame: ratio bit clocks long, pulse 32 bit clocks high
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tcnt_r <= 10'h000;
         tpulse_r <= 1'b0;
      end
      else if (ref_fall)
      begin
         tcnt_r <= (tcnt_r >= tlen - 10'h001) ? 10'h000
            : tcnt_r + 10'h001;
         tpulse_r <= (tcnt_r >= tlen - 10'h001)
            || (tcnt_r < `ASP_TDM_PULSE - 10'h001);
      end
   end

   // Pin drive: enables low only on the master port
   assign in_bit_clock_o = gbclk_r;
   assign in_word_clock_o = gbit_r[5];
   assign in_bit_clock_oe_n = ~in_master;
   assign in_word_clock_oe_n = ~in_master;
   assign out_bit_clock_o = tdm ? s_ref : gbclk_r;
   assign out_word_clock_o = tdm ? tpulse_r : gbit_r[5];
   assign out_bit_clock_oe_n = ~out_master;
   assign out_word_clock_oe_n = ~out_master;

   // Input port deserialiser on bit clock rising edges
   logic ib, il, ib_q, ilr_r, ib_rise, in_left;
   logic [31:0] ish_r;
   logic [6:0] icnt_r;
   logic [23:0] iw, il_w_r, ir_w_r;
   assign ib = in_master ? gbclk_r : s_ib;
   assign il = in_master ? gbit_r[5] : s_il;
   assign ib_rise = ib & ~ib_q;
   assign iw = in_word(in_fmt, ish_r, icnt_r);
   assign in_left = (in_fmt[0] && !in_fmt[1] && !in_fmt[2]) ? ~ilr_r : ilr_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ib_q <= 1'b0;
         ilr_r <= 1'b0;
         ish_r <= 32'h0;
         icnt_r <= 7'h00;
         il_w_r <= 24'h0;
         ir_w_r <= 24'h0;
         core_in_valid <= 1'b0;
      end
      else
      begin
         ib_q <= ib;
         core_in_valid <= 1'b0;
         if (ib_rise && il != ilr_r)
         begin
            // Word clock edge closes the half just received
            ilr_r <= il;
            ish_r <= {31'h0, s_sd};
            icnt_r <= 7'h01;
            if (in_left)
               il_w_r <= iw;
            else
            begin
               ir_w_r <= iw;
               core_in_valid <= 1'b1;
            end
         end
         else if (ib_rise)
         begin
            ish_r <= {ish_r[30:0], s_sd};
            icnt_r <= (icnt_r == 7'h7f) ? icnt_r : icnt_r + 7'h01;
         end
      end
   end
   assign core_in_left = {il_w_r, 4'h0};
   assign core_in_right = {ir_w_r, 4'h0};

   // Output serialiser: data changes on bit clock falling edges
   logic ob, ol, ob_q, olr_r, ob_fall, chg, left_lvl, new_frame, obit;
   logic [6:0] ocnt_r, olen_r, idx_nxt, off;
   logic [15:0] lfsr_r;
   logic [23:0] otl_r, otr_r, dl, dr, wsel;
   logic signed [7:0] pos;
   assign ob = out_master ? (tdm ? s_ref : gbclk_r) : s_ob;
   assign ol = out_master ? (tdm ? tpulse_r : gbit_r[5]) : s_ol;
   assign ob_fall = ~ob & ob_q;
   assign chg = ol != olr_r;
   assign left_lvl = out_fmt != `ASP_OUTFMT_I2S;
   assign new_frame = ob_fall && chg && ol == left_lvl;
   // In TDM only the pulse rise restarts the count, so the right slot follows
   assign idx_nxt = (chg && !(tdm && ol != left_lvl)) ? 7'h00
      : (ocnt_r == 7'h7f ? ocnt_r : ocnt_r + 7'h01);
   assign dl = dither(bypass_active ? {il_w_r, 4'h0} : core_out_left, ow,
      lfsr_r, bypass_active);
   assign dr = dither(bypass_active ? {ir_w_r, 4'h0} : core_out_right, ow,
      ~lfsr_r, bypass_active);
   always_comb
   begin
      off = 7'h00;
      wsel = (ol == left_lvl) ? (chg ? dl : otl_r) : otr_r;
      if (out_fmt == `ASP_OUTFMT_I2S)
         off = 7'h01;
      else if (out_fmt == `ASP_OUTFMT_RJ)
         off = olen_r - ow;
      else if (tdm && idx_nxt[5])
      begin
         off = 7'h20;
         wsel = otr_r;
      end
      else if (tdm)
         wsel = chg ? dl : otl_r;
      pos = $signed({1'b0, idx_nxt}) - $signed({1'b0, off});
      obit = 1'b0;
      if (pos >= 8'sd0 && pos < $signed({1'b0, ow}) && !(tdm && idx_nxt[6]))
         obit = wsel[5'h17 - pos[4:0]];
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ob_q <= 1'b0;
         olr_r <= 1'b0;
         ocnt_r <= 7'h00;
         olen_r <= 7'h40;
         otl_r <= 24'h0;
         otr_r <= 24'h0;
         out_serial_data <= 1'b0;
         core_out_take <= 1'b0;
         lfsr_r <= 16'hace1;
      end
      else
      begin
         ob_q <= ob;
         lfsr_r <= {lfsr_r[14:0],
            lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
         core_out_take <= new_frame;
         if (ob_fall)
         begin
            ocnt_r <= idx_nxt;
            out_serial_data <= obit;
            olr_r <= ol;
            if (chg)
               olen_r <= ocnt_r + 7'h01;
         end
         if (new_frame)
         begin
            // Whole stereo pair latched at the start of the left slot
            otl_r <= dl;
            otr_r <= dr;
         end
      end
   end

   // Checks on the behaviour above
   property p_in_drive;
      @(posedge clk) disable iff (rst)
      in_master |-> !in_bit_clock_oe_n && !in_word_clock_oe_n;
   endproperty
   a_in_drive: assert property (p_in_drive)
      else $error("input port master but pins not driven");
   property p_in_release;
      @(posedge clk) disable iff (rst)
      !in_master |-> in_bit_clock_oe_n && in_word_clock_oe_n;
   endproperty
   a_in_release: assert property (p_in_release)
      else $error("input port slave but pins driven");
   property p_one_master;
      @(posedge clk) disable iff (rst) !(in_master && out_master);
   endproperty
   a_one_master: assert property (p_one_master)
      else $error("both ports master");
   property p_word_half;
      @(posedge clk) disable iff (rst)
      $changed(gbit_r[5]) |-> gbit_r[4:0] == 5'h00 && $past(gbclk_r);
   endproperty
   a_word_half: assert property (p_word_half)
      else $error("master word clock not at 32 bit boundary");
   property p_tdm_pulse;
      @(posedge clk) disable iff (rst)
      $fell(tpulse_r) |-> tcnt_r == `ASP_TDM_PULSE;
   endproperty
   a_tdm_pulse: assert property (p_tdm_pulse)
      else $error("TDM pulse not 32 bit clocks wide");
   property p_byp_dem;
      @(posedge clk) disable iff (rst)
      bypass_active |-> cfg_deemphasis == 2'h0;
   endproperty
   a_byp_dem: assert property (p_byp_dem)
      else $error("de-emphasis active in passthrough");
   property p_reset_dflt;
      @(posedge clk) disable iff (rst)
      $past(rst) |-> ctl3_r == 8'h00 && ctl2_r == 8'h00;
   endproperty
   a_reset_dflt: assert property (p_reset_dflt)
      else $error("format, depth or de-emphasis default wrong");
   property p_depth;
      @(posedge clk) disable iff (rst)
      s_sw |-> cfg_buffer_depth == (7'h40 >> ctl2_r[1:0]);
   endproperty
   a_depth: assert property (p_depth)
      else $error("buffer depth does not follow code");
   c_in_pair: cover property (@(posedge clk) core_in_valid);
   c_bypass: cover property (@(posedge clk) bypass_active && core_out_take);
   c_tdm: cover property (@(posedge clk) out_master && tdm && $rose(tpulse_r));
endmodule : asp_audio_port
`default_nettype wire

// file: asp_cfg.svh
// Purpose: Constants for the serial audio port section.
// Assumes: Registers are eight bits wide on a plain strobe port.
// Notes: Field macros expand to part-select ranges or single bit indices.
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_REG_CTL1 8'h01
`define ASP_REG_CTL2 8'h02
`define ASP_REG_CTL3 8'h03
`define ASP_REG_STAT 8'h08
`define ASP_CTL1_RST 8'h00
`define ASP_CTL2_RST 8'h00
`define ASP_CTL3_RST 8'h00
`define ASP_F_MODE 2:0
`define ASP_F_BYP 3
`define ASP_F_DEPTH 1:0
`define ASP_F_DDS 2
`define ASP_F_DEMPH 4:3
`define ASP_F_INFMT 2:0
`define ASP_F_OUTFMT 5:4
`define ASP_F_WLEN 7:6
`define ASP_OUTFMT_LJ 2'h0
`define ASP_OUTFMT_I2S 2'h1
`define ASP_OUTFMT_TDM 2'h2
`define ASP_OUTFMT_RJ 2'h3
`define ASP_TDM_PULSE 10'h020
`define ASP_DEPTH_MAX 7'h40
`define ASP_LJ_BITS 7'h18
`define ASP_I2S_BITS 7'h19
`define ASP_SYNC_W 23
`endif

// file: asp_far_end.sv
// Purpose: Audio source and sink that sit on the two serial ports.
// Assumes: Slave clocks at 64 bit clocks per frame, left-justified.
// Notes: Clocks stand still while their run input is low; idle data bits toggle.
`timescale 1ns/100ps
`default_nettype none
module asp_far_end
(
   input wire logic run_src,
   input wire logic [23:0] left_word,
   input wire logic [23:0] right_word,
   output logic src_bck,
   output logic src_wck,
   output logic src_data,
   input wire logic run_snk,
   output logic snk_bck,
   output logic snk_wck,
   input wire logic snk_data,
   output logic [31:0] snk_left,
   output logic [15:0] snk_frames
);
   int j; // Source bit position in its frame
   int k; // Sink bit position in its frame
   logic [23:0] word; // Word the source is shifting
   logic [31:0] shift; // Left half being collected by the sink
   bit src_go; // Source has taken its phase offset
   bit snk_go; // Sink has taken its phase offset
   initial
   begin
      {src_bck, src_wck, src_data, snk_bck, snk_wck} = 5'h00;
      snk_left = 32'h0;
      snk_frames = 16'h0;
   end
   // Source: 80 ns bit clock, data changes on the falling edge
   always
   begin
      wait (run_src);
      if (!src_go)
         #1.5 src_go = 1'b1; // Keep edges off the system clock grid
      for (j = 0; j < 64; j++)
      begin
         word = (j < 32) ? left_word : right_word;
         src_bck = 1'b0;
         src_wck = (j < 32);
         if (j % 32 < 24)
            src_data = word[23 - j % 32];
         else
            src_data = ~src_data; // Unused slot, no stale level
         #40;
         src_bck = 1'b1;
         #40;
      end
   end
   // Sink: own bit clock and word clock, samples on the rising edge
   always
   begin
      wait (run_snk);
      if (!snk_go)
         #2.5 snk_go = 1'b1;
      for (k = 0; k < 64; k++)
      begin
         snk_bck = 1'b0;
         snk_wck = (k < 32);
         #40;
         snk_bck = 1'b1;
         if (k < 32)
            shift[31 - k] = snk_data;
         #40;
      end
      snk_left = shift;
      snk_frames = snk_frames + 16'h0001;
   end
endmodule : asp_far_end
`default_nettype wire

// file: asp_pkg.sv
// Purpose: Types for the serial audio port section.
// Assumes: Constants live in asp_cfg.svh.
// Notes: Master role is decoded from the port mode code.
package asp_pkg;
   // Which serial port, if any, generates its own clocks
   typedef enum logic [1:0] {ASP_ALL_SLAVE, ASP_IN_MASTER, ASP_OUT_MASTER}
      asp_role_type;
endpackage : asp_pkg

// file: testbench.sv
// Purpose: Self-checking bench for the serial audio port section.
// Assumes: Register port with one-cycle strobes, far end clocking the slave ports.
// Notes: Master clocks are measured in bit clocks per word clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sw_mode_pin = 1'b1;
   logic [2:0] port_mode_pin = 3'h0;
   logic [2:0] in_format_sel = 3'h0;
   logic [1:0] out_format_sel = 2'h0;
   logic [1:0] out_word_length_sel = 2'h0;
   logic passthru_pin = 1'b0;
   logic [1:0] buffer_depth_sel = 2'h0;
   logic direct_downsample_sel = 1'b0;
   logic [1:0] deemphasis_sel = 2'h0;
   logic section_ref_clock = 1'b0;
   logic ibo, ibo_n, iwo, iwo_n, obo, obo_n, owo, owo_n;
   logic src_bck, src_wck, in_serial_data, snk_bck, snk_wck;
   logic in_bck, in_wck, out_bck, out_wck, out_serial_data;
   logic [27:0] core_in_left, core_in_right;
   logic [27:0] core_out_left = 28'h0123456;
   logic [27:0] core_out_right = 28'hfedcba9;
   logic core_in_valid, core_out_take, cfg_direct_downsample;
   logic bypass_active;
   logic [6:0] cfg_buffer_depth;
   logic [1:0] cfg_deemphasis;
   logic run_src = 1'b0;
   logic run_snk = 1'b0;
   logic [31:0] snk_left;
   logic [15:0] snk_frames;
   logic [23:0] lw_val = 24'h9a5c31; // Negative left sample
   logic [23:0] rw_val = 24'h35c3a7;
   int fails = 0;
   int compares = 0;
   int i, hi, tot;
   logic [15:0] f0;
   // Shared pins: block drives while its enable is low
   assign in_bck = ibo_n ? src_bck : ibo;
   assign in_wck = iwo_n ? src_wck : iwo;
   assign out_bck = obo_n ? snk_bck : obo;
   assign out_wck = owo_n ? snk_wck : owo;
   always #2 clk = ~clk;
   always #20 section_ref_clock = ~section_ref_clock;
   asp_audio_port dut
   (
      .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sw_mode_pin, .port_mode_pin, .in_format_sel, .out_format_sel,
      .out_word_length_sel, .passthru_pin, .buffer_depth_sel,
      .direct_downsample_sel, .deemphasis_sel, .section_ref_clock,
      .in_bit_clock_i(in_bck), .in_bit_clock_o(ibo),
      .in_bit_clock_oe_n(ibo_n), .in_word_clock_i(in_wck),
      .in_word_clock_o(iwo), .in_word_clock_oe_n(iwo_n), .in_serial_data,
      .out_bit_clock_i(out_bck), .out_bit_clock_o(obo),
      .out_bit_clock_oe_n(obo_n), .out_word_clock_i(out_wck),
      .out_word_clock_o(owo), .out_word_clock_oe_n(owo_n),
      .out_serial_data, .core_in_left, .core_in_right, .core_in_valid,
      .core_out_left, .core_out_right, .core_out_take, .cfg_buffer_depth,
      .cfg_direct_downsample, .cfg_deemphasis, .bypass_active
   );
   asp_far_end far
   (
      .run_src, .left_word(lw_val), .right_word(rw_val), .src_bck,
      .src_wck, .src_data(in_serial_data), .run_snk, .snk_bck, .snk_wck,
      .snk_data(out_serial_data), .snk_left, .snk_frames
   );
   // Step to just after the next rising edge
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic conclude();
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   // A wait that used up its bound ends the run
   task automatic guard(input int n, input int lim);
      if (n >= lim)
      begin
         fails++;
         $display("[ERR] wait expected event seen timeout");
         conclude();
      end
   endtask : guard
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : bus_wr
   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(what, {24'h0, exp}, {24'h0, reg_rdata});
   endtask : rd_chk
   // Count bit clock rises over one word clock period of a master port
   task automatic measure(input logic sel, output int h, output int t);
      int n;
      logic pw, pb;
      h = 0;
      t = 0;
      n = 0;
      do
      begin
         pw = sel ? owo : iwo;
         tick();
         n++;
      end while (!((sel ? owo : iwo) && !pw) && n < 3000);
      guard(n, 3000);
      n = 0;
      do
      begin
         pw = sel ? owo : iwo;
         pb = sel ? obo : ibo;
         tick();
         n++;
         if ((sel ? obo : ibo) && !pb)
         begin
            t++;
            if (sel ? owo : iwo)
               h++;
         end
      end while (!((sel ? owo : iwo) && !pw) && n < 3000);
      guard(n, 3000);
   endtask : measure
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // Reset values of the software settings
      rd_chk("ctl1", 8'h01, 8'h00);
      rd_chk("ctl2", 8'h02, 8'h00);
      rd_chk("ctl3", 8'h03, 8'h00);
      check("depth", 32'h40, {25'h0, cfg_buffer_depth});
      check("dds", 32'h0, {31'h0, cfg_direct_downsample});
      check("demph", 32'h0, {30'h0, cfg_deemphasis});
      rd_chk("status", 8'h08, 8'h08);
      bus_wr(8'h03, 8'hff);
      rd_chk("ctl3 mask", 8'h03, 8'hf7);
      bus_wr(8'h03, 8'h00);
      bus_wr(8'h05, 8'haa);
      rd_chk("unmapped", 8'h05, 8'h00);
      $display("Test registers done");
      // Pin settings in hardware mode, every code
      sw_mode_pin <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         @(posedge clk);
         {passthru_pin, deemphasis_sel} <= 3'(i);
         buffer_depth_sel <= 2'(i);
         direct_downsample_sel <= i[0];
         repeat (6) tick();
         check("depth", 32'h40 >> i[1:0], {25'h0, cfg_buffer_depth});
         check("dds", i[0], {31'h0, cfg_direct_downsample});
         check("demph", i[2] ? 0 : i[1:0], {30'h0, cfg_deemphasis});
         check("bypass", i[2], {31'h0, bypass_active});
      end
      @(posedge clk);
      {sw_mode_pin, passthru_pin} <= 2'b10;
      bus_wr(8'h02, 8'h1e);
      repeat (2) tick();
      check("depth sw", 32'h10, {25'h0, cfg_buffer_depth});
      check("dds sw", 32'h1, {31'h0, cfg_direct_downsample});
      check("demph sw", 32'h3, {30'h0, cfg_deemphasis});
      bus_wr(8'h02, 8'h00);
      $display("Test settings done");
      // Input port, 24-bit left-justified words
      run_src <= 1'b1;
      repeat (2)
      begin
         for (i = 0; i < 4000 && core_in_valid !== 1'b1; i++)
            tick();
         guard(i, 4000);
         tick();
      end
      check("in left", {lw_val, 4'h0}, core_in_left);
      check("in right", {rw_val, 4'h0}, core_in_right);
      $display("Test input done");
      // Passthrough to the output port at each word length
      bus_wr(8'h01, 8'h08);
      run_snk <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         bus_wr(8'h03, 8'(i << 6));
         f0 = snk_frames;
         for (hi = 0; hi < 6000 && snk_frames - f0 < 3; hi++)
            tick();
         guard(hi, 6000);
         tot = (i == 0) ? 24 : 22 - 2 * i;
         check("out word", {lw_val, 8'h0} & ~(32'hffffffff >> tot), snk_left);
      end
      // Normal conversion: dithered core word, take pulse at frame start
      bus_wr(8'h01, 8'h00);
      bus_wr(8'h03, 8'h00);
      f0 = snk_frames;
      for (hi = 0; hi < 6000 && snk_frames - f0 < 3; hi++)
         tick();
      guard(hi, 6000);
      check("dither", 32'h01234, {12'h0, snk_left[31:12]});
      for (hi = 0; hi < 20 && core_out_take !== 1'b1; hi++)
         tick();
      check("take", 32'h1, {31'h0, core_out_take});
      @(posedge clk);
      {run_src, run_snk} <= 2'b00;
      $display("Test passthrough done");
      // Master clocks from the reference, ratio 128
      bus_wr(8'h01, 8'h05);
      repeat (8) tick();
      check("in oe", 32'h0, {30'h0, ibo_n, iwo_n});
      check("out oe", 32'h3, {30'h0, obo_n, owo_n});
      rd_chk("status", 8'h08, 8'h09);
      measure(1'b0, hi, tot);
      check("in bits", 32'd64, tot);
      check("in high", 32'd32, hi);
      bus_wr(8'h01, 8'h01);
      repeat (8) tick();
      check("out oe m", 32'h0, {30'h0, obo_n, owo_n});
      measure(1'b1, hi, tot);
      check("out bits", 32'd64, tot);
      check("out high", 32'd32, hi);
      // TDM master: bit clock is the reference, 128 per frame
      bus_wr(8'h03, 8'h20);
      repeat (8) tick();
      measure(1'b1, hi, tot);
      check("tdm bits", 32'd128, tot);
      check("tdm high", 32'd32, hi);
      $display("Test masters done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
